// *** transform_bank_pkg.sv ***
/*
 * shared constants and types for the transform result register bank.
 * assumes a 16-bit byte address on a 32-bit classic wishbone bus.
 */
package transform_bank_pkg;
   localparam int ADR_W = 16;
   localparam int DATA_W = 16;
   localparam int RESULT_W = 18;
   localparam int ACC_W = 32;
   localparam int CNT_W = 14;
   localparam int IRQ_W = 4;
   localparam int COUNT_W = 4;
   ////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [15:0] FILTER_OFS = 16'h2044;
   localparam logic [15:0] REAL_OFS = 16'h2078;
   localparam logic [15:0] IMAG_OFS = 16'h207c;
   localparam logic [15:0] LOWPASS_OFS = 16'h2080;
   localparam logic [15:0] TEMP_OFS = 16'h2084;
   localparam logic [15:0] CONFIG_OFS = 16'h20d0;
   localparam logic [15:0] IRQ_STAT_OFS = 16'h3000;
   localparam logic [15:0] IRQ_CLR_OFS = 16'h3004;
   localparam logic [15:0] IRQ_EN_OFS = 16'h3008;
   ////////////////////////////////////////////////////////////////////////
   // reset values and writable masks
   localparam logic [31:0] CONFIG_RST = 32'h00000090;
   localparam logic [31:0] CONFIG_MASK = 32'h003000f1;
   localparam logic [31:0] FILTER_RST = 32'h00000000;
   localparam logic [31:0] FILTER_MASK = 32'hffff01c0;
   ////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int INSEL_LSB = 20;
   localparam int COUNT_LSB = 4;
   localparam int BYPASS_BIT = 6;
   localparam int AVG_BIT = 7;
   localparam int RUN_BIT = 8;
   localparam int OFFSET_LSB = 16;
   localparam int IRQ_DFT = 0;
   localparam int IRQ_LOWPASS = 2;
   localparam int IRQ_TEMP = 3;
   ////////////////////////////////////////////////////////////////////////
   // input select codes and sample count limits
   localparam logic [1:0] SEL_LOWPASS_A = 2'h0;
   localparam logic [1:0] SEL_CORRECTED = 2'h1;
   localparam logic [1:0] SEL_RAW = 2'h2;
   localparam logic [1:0] SEL_LOWPASS_B = 2'h3;
   localparam logic [3:0] COUNT_MAX_CODE = 4'hc;
   localparam logic [3:0] COUNT_BASE_SHIFT = 4'h2;
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic valid;
      logic [DATA_W-1:0] data;
   } sample_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ACC = 2'b10
   } engine_state_t;
endpackage : transform_bank_pkg

// *** sample_select.sv ***
/*
 * transform input selection with the gain/offset correction stage.
 * assumes all sample strobes are synchronous one-cycle pulses.
 */
`timescale 1ns/100ps
module sample_select (
   input wire logic clk_i,
   input wire logic rst_i,
   input transform_bank_pkg::sample_t raw_i,
   input transform_bank_pkg::sample_t third_i,
   input transform_bank_pkg::sample_t lowpass_i,
   input transform_bank_pkg::sample_t avg_i,
   input wire logic [1:0] insel_i,
   input wire logic avg_en_i,
   input wire logic bypass_i,
   input wire logic [15:0] offset_i,
   output transform_bank_pkg::sample_t sample_o
);
   transform_bank_pkg::sample_t pre;
   transform_bank_pkg::sample_t corrected;
   transform_bank_pkg::sample_t sel_next;
   transform_bank_pkg::sample_t sel_reg;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      pre = bypass_i ? raw_i : third_i;
      corrected.valid = pre.valid;
      corrected.data = pre.data - offset_i;
      if (avg_en_i) begin
         sel_next = avg_i;
      end else begin
         unique case (insel_i)
            transform_bank_pkg::SEL_CORRECTED: sel_next = corrected;
            transform_bank_pkg::SEL_RAW: sel_next = raw_i;
            default: sel_next = lowpass_i;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sel_reg <= '0;
      end else begin
         sel_reg <= sel_next;
      end
   end

   assign sample_o = sel_reg;

   ////////////////////////////////////////////////////////////////////////
   property p_avg_wins;
      @(posedge clk_i) disable iff (rst_i)
      avg_en_i |=> sample_o == $past(avg_i);
   endproperty
   a_avg_wins: assert property (p_avg_wins)
      else $error("averaged sample not selected");

   property p_lowpass_codes;
      @(posedge clk_i) disable iff (rst_i)
      (!avg_en_i && (insel_i == transform_bank_pkg::SEL_LOWPASS_A ||
         insel_i == transform_bank_pkg::SEL_LOWPASS_B))
         |=> sample_o == $past(lowpass_i);
   endproperty
   a_lowpass_codes: assert property (p_lowpass_codes)
      else $error("low-pass codes not routed alike");

   property p_corrected;
      @(posedge clk_i) disable iff (rst_i)
      (!avg_en_i && insel_i == transform_bank_pkg::SEL_CORRECTED && bypass_i)
         |=> sample_o.data == $past(raw_i.data - offset_i);
   endproperty
   a_corrected: assert property (p_corrected)
      else $error("bypassed raw data not corrected");

   property p_third_path;
      @(posedge clk_i) disable iff (rst_i)
      (!avg_en_i && insel_i == transform_bank_pkg::SEL_CORRECTED && !bypass_i)
         |=> sample_o.valid == $past(third_i.valid) &&
         sample_o.data == $past(third_i.data - offset_i);
   endproperty
   a_third_path: assert property (p_third_path)
      else $error("third order output not used");

   property p_raw;
      @(posedge clk_i) disable iff (rst_i)
      (!avg_en_i && insel_i == transform_bank_pkg::SEL_RAW)
         |=> sample_o == $past(raw_i);
   endproperty
   a_raw: assert property (p_raw)
      else $error("raw data not passed uncorrected");
endmodule : sample_select

// *** transform_bank.sv ***
/*
 * transform result and input select register bank with a single-bin
 * quadrature transform engine, behind a classic wishbone slave.
 * assumes upstream filter chain delivers one-cycle sample strobes.
 */
// Behaviour
// - imaginary result is 18-bit twos complement, bits 31:18 read zero.
// - low-pass filter output sits in bits 15:0, upper half zero.
// - new low-pass result sets interrupt flag bit 2.
// - temperature result is 16 bits in the low half, upper zero.
// - input select codes 00 and 11 both route the low-pass output.
// - code 01 routes the gain/offset corrected stage output.
// - code 10 routes raw samples; software uses it at 800 kHz only.
// - averaging enable overrides the input select field.
// - four-bit sample count field at bits 7:4, reset 9, 4..16384.
// - count code 0 is 4 samples, code 1 is 8, doubling up to code 12; codes 13..15 also give 16384.
// - configuration resets to 0x90, reserved bits read zero.
// - count code 9 processes 2048 samples.
// - bypass sends raw data to the correction stage, not third order.
// - real result is an 18-bit twos complement value.
`timescale 1ns/100ps
module transform_bank (
   input wire logic REF_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [15:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input transform_bank_pkg::sample_t RAW_I,
   input transform_bank_pkg::sample_t THIRD_I,
   input transform_bank_pkg::sample_t LOWPASS_I,
   input transform_bank_pkg::sample_t AVG_I,
   input transform_bank_pkg::sample_t TEMP_I,
   output logic IRQ_O
);
   localparam int RW = transform_bank_pkg::RESULT_W;
   localparam int AW = transform_bank_pkg::ACC_W;
   localparam int CW = transform_bank_pkg::CNT_W;
   localparam int DW = transform_bank_pkg::DATA_W;
   localparam int IW = transform_bank_pkg::IRQ_W;

   logic ack_reg;
   logic [31:0] dat_reg;
   logic [31:0] dat_next;
   logic irq_reg;
   logic [31:0] config_reg;
   logic [31:0] filter_reg;
   logic [RW-1:0] real_reg;
   logic [RW-1:0] imag_reg;
   logic [DW-1:0] lowpass_reg;
   logic [DW-1:0] temp_reg;
   logic [IW-1:0] irq_stat_reg;
   logic [IW-1:0] irq_stat_next;
   logic [IW-1:0] irq_en_reg;
   transform_bank_pkg::engine_state_t state_reg;
   logic [AW-1:0] acc_re_reg;
   logic [AW-1:0] acc_im_reg;
   logic [AW-1:0] re_next;
   logic [AW-1:0] im_next;
   logic [CW-1:0] cnt_reg;
   logic [1:0] phase_reg;
   logic [CW-1:0] n_last;
   logic [CW:0] n_points;
   logic [3:0] code_eff;
   logic [AW-1:0] x_ext;
   transform_bank_pkg::sample_t sample;
   logic req;
   logic wr;
   logic last_sample;
   logic run;
   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [31:0] merge(input logic [31:0] old_v,
         input logic [31:0] new_v, input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge
   function automatic logic [RW-1:0] sat(input logic [AW-1:0] a);
      logic signed [AW-1:0] s;
      logic signed [AW-1:0] hi;
      logic signed [AW-1:0] lo;
      s = $signed(a);
      hi = AW'((1 << (RW - 1)) - 1);
      lo = -AW'(1 << (RW - 1));
      if (s > hi) begin
         return {1'b0, {(RW-1){1'b1}}};
      end else if (s < lo) begin
         return {1'b1, {(RW-1){1'b0}}};
      end
      return a[RW-1:0];
   endfunction : sat
   ////////////////////////////////////////////////////////////////////////
   // bus slave
   assign req = WB_CYC_I && WB_STB_I;
   assign wr = req && WB_WE_I && ack_reg;

   always_comb begin
      unique case (WB_ADR_I)
         transform_bank_pkg::REAL_OFS: dat_next = 32'(real_reg);
         transform_bank_pkg::IMAG_OFS: dat_next = 32'(imag_reg);
         transform_bank_pkg::LOWPASS_OFS: dat_next = 32'(lowpass_reg);
         transform_bank_pkg::TEMP_OFS: dat_next = 32'(temp_reg);
         transform_bank_pkg::CONFIG_OFS: dat_next = config_reg;
         transform_bank_pkg::FILTER_OFS: dat_next = filter_reg;
         transform_bank_pkg::IRQ_STAT_OFS: dat_next = 32'(irq_stat_reg);
         transform_bank_pkg::IRQ_EN_OFS: dat_next = 32'(irq_en_reg);
         default: dat_next = 32'h00000000;
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end else begin
         ack_reg <= req && !ack_reg;
         dat_reg <= dat_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // configuration registers
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         config_reg <= transform_bank_pkg::CONFIG_RST;
      end else if (wr && WB_ADR_I == transform_bank_pkg::CONFIG_OFS) begin
         config_reg <= merge(config_reg, WB_DAT_I, WB_SEL_I) &
            transform_bank_pkg::CONFIG_MASK;
      end
   end
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         filter_reg <= transform_bank_pkg::FILTER_RST;
      end else if (wr && WB_ADR_I == transform_bank_pkg::FILTER_OFS) begin
         filter_reg <= merge(filter_reg, WB_DAT_I, WB_SEL_I) &
            transform_bank_pkg::FILTER_MASK;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // input selection
   sample_select u_select (
      .clk_i(REF_CLK_I),
      .rst_i(SYS_RST_I),
      .raw_i(RAW_I),
      .third_i(THIRD_I),
      .lowpass_i(LOWPASS_I),
      .avg_i(AVG_I),
      .insel_i(config_reg[transform_bank_pkg::INSEL_LSB +: 2]),
      .avg_en_i(filter_reg[transform_bank_pkg::AVG_BIT]),
      .bypass_i(filter_reg[transform_bank_pkg::BYPASS_BIT]),
      .offset_i(filter_reg[transform_bank_pkg::OFFSET_LSB +: DW]),
      .sample_o(sample)
   );
   ////////////////////////////////////////////////////////////////////////
   // transform engine
   always_comb begin
      code_eff = config_reg[transform_bank_pkg::COUNT_LSB +:
         transform_bank_pkg::COUNT_W];
      if (code_eff > transform_bank_pkg::COUNT_MAX_CODE) begin
         code_eff = transform_bank_pkg::COUNT_MAX_CODE;
      end
      n_points = (CW+1)'(1) <<
         (code_eff + transform_bank_pkg::COUNT_BASE_SHIFT);
      n_last = CW'(n_points - (CW+1)'(1));
   end

   assign run = filter_reg[transform_bank_pkg::RUN_BIT];
   assign x_ext = AW'($signed(sample.data));
   assign last_sample = (state_reg == transform_bank_pkg::ST_ACC) &&
      sample.valid && (cnt_reg == n_last);

   // quarter-rate bin: multiply by exp(-j*pi*n/2)
   always_comb begin
      re_next = acc_re_reg;
      im_next = acc_im_reg;
      unique case (phase_reg)
         2'h0: re_next = acc_re_reg + x_ext;
         2'h1: im_next = acc_im_reg - x_ext;
         2'h2: re_next = acc_re_reg - x_ext;
         2'h3: im_next = acc_im_reg + x_ext;
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I || !run || (wr &&
            WB_ADR_I == transform_bank_pkg::CONFIG_OFS)) begin
         // reset, stop or reconfiguring restarts the block
         state_reg <= (run && !SYS_RST_I) ? transform_bank_pkg::ST_ACC :
            transform_bank_pkg::ST_IDLE;
         acc_re_reg <= '0;
         acc_im_reg <= '0;
         cnt_reg <= '0;
         phase_reg <= 2'h0;
      end else begin
         unique case (state_reg)
            transform_bank_pkg::ST_IDLE: begin
               state_reg <= transform_bank_pkg::ST_ACC;
            end
            transform_bank_pkg::ST_ACC: begin
               if (last_sample) begin
                  acc_re_reg <= '0;
                  acc_im_reg <= '0;
                  cnt_reg <= '0;
                  phase_reg <= 2'h0;
               end else if (sample.valid) begin
                  acc_re_reg <= re_next;
                  acc_im_reg <= im_next;
                  cnt_reg <= cnt_reg + CW'(1);
                  phase_reg <= phase_reg + 2'h1;
               end
            end
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // result registers: hardware update beats a software write
   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         real_reg <= '0;
         imag_reg <= '0;
      end else if (last_sample) begin
         real_reg <= sat(re_next);
         imag_reg <= sat(im_next);
      end else if (wr) begin
         if (WB_ADR_I == transform_bank_pkg::REAL_OFS) begin
            real_reg <= RW'(merge(32'(real_reg), WB_DAT_I, WB_SEL_I));
         end
         if (WB_ADR_I == transform_bank_pkg::IMAG_OFS) begin
            imag_reg <= RW'(merge(32'(imag_reg), WB_DAT_I, WB_SEL_I));
         end
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         lowpass_reg <= '0;
      end else if (LOWPASS_I.valid) begin
         lowpass_reg <= LOWPASS_I.data;
      end else if (wr && WB_ADR_I == transform_bank_pkg::LOWPASS_OFS) begin
         lowpass_reg <= DW'(merge(32'(lowpass_reg), WB_DAT_I, WB_SEL_I));
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         temp_reg <= '0;
      end else if (TEMP_I.valid) begin
         temp_reg <= TEMP_I.data;
      end else if (wr && WB_ADR_I == transform_bank_pkg::TEMP_OFS) begin
         temp_reg <= DW'(merge(32'(temp_reg), WB_DAT_I, WB_SEL_I));
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // interrupts: write-one-to-clear, a new event wins over the clear
   always_comb begin
      irq_stat_next = irq_stat_reg;
      if (wr && WB_ADR_I == transform_bank_pkg::IRQ_CLR_OFS &&
            WB_SEL_I[0]) begin
         irq_stat_next = irq_stat_reg & ~WB_DAT_I[IW-1:0];
      end
      if (last_sample) begin
         irq_stat_next[transform_bank_pkg::IRQ_DFT] = 1'b1;
      end
      if (LOWPASS_I.valid) begin
         irq_stat_next[transform_bank_pkg::IRQ_LOWPASS] = 1'b1;
      end
      if (TEMP_I.valid) begin
         irq_stat_next[transform_bank_pkg::IRQ_TEMP] = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         irq_stat_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_reg <= |(irq_stat_next & irq_en_reg);
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (SYS_RST_I) begin
         irq_en_reg <= '0;
      end else if (wr && WB_ADR_I == transform_bank_pkg::IRQ_EN_OFS &&
            WB_SEL_I[0]) begin
         irq_en_reg <= WB_DAT_I[IW-1:0];
      end
   end

   assign WB_ACK_O = ack_reg;
   assign WB_DAT_O = dat_reg;
   assign IRQ_O = irq_reg;
   ////////////////////////////////////////////////////////////////////////
   property p_imag_upper_zero;
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      (ack_reg && !WB_WE_I && WB_ADR_I == transform_bank_pkg::IMAG_OFS)
         |-> dat_reg == {{(32-RW){1'b0}}, $past(imag_reg)};
   endproperty
   a_imag_upper_zero: assert property (p_imag_upper_zero)
      else $error("imaginary read wrong");
   property p_lowpass_read;
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      LOWPASS_I.valid ##1 !LOWPASS_I.valid [*2] ##1 (ack_reg && !WB_WE_I
         && WB_ADR_I == transform_bank_pkg::LOWPASS_OFS)
         |-> dat_reg == {16'h0000, $past(LOWPASS_I.data, 3)};
   endproperty
   a_lowpass_read: assert property (p_lowpass_read)
      else $error("low-pass read wrong");
   property p_lowpass_flag;
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      LOWPASS_I.valid |=> irq_stat_reg[transform_bank_pkg::IRQ_LOWPASS];
   endproperty
   a_lowpass_flag: assert property (p_lowpass_flag)
      else $error("low-pass flag not set");
   property p_temp_capture;
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      TEMP_I.valid |=> temp_reg == $past(TEMP_I.data);
   endproperty
   a_temp_capture: assert property (p_temp_capture)
      else $error("temperature not captured");
   property p_config_reset;
      @(posedge REF_CLK_I)
      $fell(SYS_RST_I) |-> config_reg == transform_bank_pkg::CONFIG_RST
         && (config_reg & ~transform_bank_pkg::CONFIG_MASK) == 32'h0;
   endproperty
   a_config_reset: assert property (p_config_reset)
      else $error("configuration reset value wrong");
   property p_count_base;
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      config_reg[7:4] == 4'h0 |-> n_last == CW'(3) &&
         (!last_sample || cnt_reg == CW'(3));
   endproperty
   a_count_base: assert property (p_count_base)
      else $error("code 0 is not 4 samples");
   property p_count_2048;
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      config_reg[7:4] == 4'h9 |-> n_last == CW'(2047);
   endproperty
   a_count_2048: assert property (p_count_2048)
      else $error("code 9 is not 2048 samples");
   property p_count_max;
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      config_reg[7:4] >= 4'hc |-> n_last == CW'(16383);
   endproperty
   a_count_max: assert property (p_count_max)
      else $error("count above 16384");
   property p_pair_update;
      @(posedge REF_CLK_I) disable iff (SYS_RST_I)
      last_sample |=> real_reg == $past(sat(re_next)) &&
         imag_reg == $past(sat(im_next)) &&
         irq_stat_reg[transform_bank_pkg::IRQ_DFT];
   endproperty
   a_pair_update: assert property (p_pair_update)
      else $error("result pair not published together");
endmodule : transform_bank

// *** test_transform_bank.sv ***
/* self-checking bench for the transform register bank.
   assumes a classic wishbone slave and one-cycle sample strobes. */
`timescale 1ns/100ps
module test_transform_bank;
   logic clk, rst, cyc, stb, we, ack, irq;
   logic [15:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q;
   transform_bank_pkg::sample_t raw_s, third_s, low_s, avg_s, temp_s;
   int mismatches = 0;
   int checks = 0;
   int groups;
   logic [17:0] re_exp, im_exp;
   logic [1:0] tsel [7] = '{2'h0, 2'h3, 2'h1, 2'h1, 2'h2, 2'h2, 2'h0};
   logic [3:0] tcnt [7] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 4'h9};
   logic tavg [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
   logic tbyp [7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
   int tamp [7] = '{3, 3, 1, 2, 1, 5, 3};

   transform_bank i_transform_bank (
      .REF_CLK_I(clk), .SYS_RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .RAW_I(raw_s), .THIRD_I(third_s),
      .LOWPASS_I(low_s), .AVG_I(avg_s), .TEMP_I(temp_s), .IRQ_O(irq)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   ////////////////////////////////////////
   task end_sim;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task wb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) begin
         mismatches++;
         end_sim();
      end else begin
         q = rdat;
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask : wb

   task rd_chk(input string name, input logic [15:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      check(name, q, exp);
   endtask : rd_chk

   // sample k of the raw, third, low-pass and averaged sources carries amplitude times k+1
   task feed(input int from, input int upto);
      for (int k = from; k < upto; k++) begin
         @(posedge clk);
         raw_s <= {1'b1, 16'(k + 1)};
         third_s <= {1'b1, 16'(2 * (k + 1))};
         low_s <= {1'b1, 16'(3 * (k + 1))};
         avg_s <= {1'b1, 16'(5 * (k + 1))};
      end
      @(posedge clk);
      raw_s.valid <= 1'b0;
      third_s.valid <= 1'b0;
      low_s.valid <= 1'b0;
      avg_s.valid <= 1'b0;
   endtask : feed

   ////////////////////////////////////////
   initial begin
      rst = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 16'h0;
      sel = 4'hf;
      wdat = 32'h0;
      q = 32'h0;
      raw_s = '0;
      third_s = '0;
      low_s = '0;
      avg_s = '0;
      temp_s = '0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rd_chk("config", transform_bank_pkg::CONFIG_OFS, 32'h00000090);
      rd_chk("imag", transform_bank_pkg::IMAG_OFS, 32'h0);
      rd_chk("real", transform_bank_pkg::REAL_OFS, 32'h0);
      rd_chk("lowpass", transform_bank_pkg::LOWPASS_OFS, 32'h0);
      rd_chk("temp", transform_bank_pkg::TEMP_OFS, 32'h0);
      rd_chk("unmapped", 16'h1000, 32'h0);
      wb(1'b1, transform_bank_pkg::CONFIG_OFS, 32'hffffffff);
      rd_chk("config mask", transform_bank_pkg::CONFIG_OFS, 32'h003000f1);
      ////////////////////////////////////////
      wb(1'b1, transform_bank_pkg::IRQ_EN_OFS, 32'h4);
      @(posedge clk);
      low_s <= {1'b1, 16'h8001};
      temp_s <= {1'b1, 16'hc0de};
      @(posedge clk);
      low_s.valid <= 1'b0;
      temp_s.valid <= 1'b0;
      rd_chk("lowpass", transform_bank_pkg::LOWPASS_OFS, 32'h00008001);
      rd_chk("temp", transform_bank_pkg::TEMP_OFS, 32'h0000c0de);
      rd_chk("status", transform_bank_pkg::IRQ_STAT_OFS, 32'hc);
      check("irq", {31'h0, irq}, 32'h1);
      wb(1'b1, transform_bank_pkg::IRQ_EN_OFS, 32'h1);
      rd_chk("clear reg", transform_bank_pkg::IRQ_CLR_OFS, 32'h0);
      check("irq masked", {31'h0, irq}, 32'h0);
      wb(1'b1, transform_bank_pkg::IRQ_CLR_OFS, 32'hf);
      rd_chk("status clr", transform_bank_pkg::IRQ_STAT_OFS, 32'h0);
      ////////////////////////////////////////
      for (int i = 0; i < 7; i++) begin
         wb(1'b1, transform_bank_pkg::FILTER_OFS, 32'h00040000);
         wb(1'b1, transform_bank_pkg::CONFIG_OFS,
            {10'h0, tsel[i], 12'h0, tcnt[i], 4'h0});
         wb(1'b1, transform_bank_pkg::FILTER_OFS,
            {16'h0004, 7'h0, 1'b1, tavg[i], tbyp[i], 6'h0});
         wb(1'b1, transform_bank_pkg::IRQ_CLR_OFS, 32'hf);
         groups = 1 << tcnt[i];
         feed(0, 4 * groups - 1);
         rd_chk("early", transform_bank_pkg::IRQ_STAT_OFS, 32'h4);
         feed(4 * groups - 1, 4 * groups);
         re_exp = 18'(-2 * tamp[i] * groups);
         im_exp = 18'(2 * tamp[i] * groups);
         rd_chk("real", transform_bank_pkg::REAL_OFS, {14'h0, re_exp});
         rd_chk("imag", transform_bank_pkg::IMAG_OFS, {14'h0, im_exp});
         rd_chk("done", transform_bank_pkg::IRQ_STAT_OFS, 32'h5);
         check("irq done", {31'h0, irq}, 32'h1);
      end
      // mid-run reset with dirty configuration and results
      wb(1'b1, transform_bank_pkg::CONFIG_OFS, 32'h00100010);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_chk("config rst", transform_bank_pkg::CONFIG_OFS, 32'h00000090);
      rd_chk("real rst", transform_bank_pkg::REAL_OFS, 32'h0);
      check("irq rst", {31'h0, irq}, 32'h0);
      end_sim();
   end
endmodule : test_transform_bank
